/* File: verilog/flash_spi_regs.svh */
// constants of the serial flash front end: bit and byte counts, address fields
// assumes inclusion by bare name from the front end module only
`ifndef FLASH_SPI_REGS_SVH
`define FLASH_SPI_REGS_SVH

`define BIT_FIRST       3'h0
`define BIT_LAST        3'h7
`define ADDR_BYTE_FIRST 10'h001
`define ADDR_BYTE_LAST  10'h003
`define BYTE_CNT_MAX    10'h3FF
// command + three address bytes + 1 to 256 data bytes
`define PP_BYTES_MIN    10'h005
`define PP_BYTES_MAX    10'h104
`define SECTOR_MSB      21
`define SECTOR_LSB      16
`define PAGE_MSB        15
`define PAGE_LSB        8
`define COLUMN_MSB      7
`define COLUMN_LSB      0
`define RX_FIFO_DEPTH   32
`define RX_FIFO_WIDTH   9

`endif

/* File: verilog/flash_spi_pkg.sv */
// types shared by the serial flash front end and its users
// assumes flash_spi_regs.svh holds the numeric constants
package flash_spi_pkg;

  typedef enum logic [2:0] {
    ST_UNARMED,
    ST_DESEL,
    ST_ACTIVE,
    ST_PAUSE
  } link_state_t;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic       aligned;
    logic       page_fit;
    logic       overrun;
    logic [9:0] bytes;
  } frame_rpt_t;

  typedef struct packed {
    logic [5:0] sector;
    logic [7:0] page;
    logic [7:0] column;
  } flash_addr_t;

endpackage

/* File: verilog/byte_fifo.sv */
// first-in first-out buffer with valid/ready on both sides and a registered output
// assumes DEPTH is a power of two and both sides share one clock
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,     // system clock
  input  wire logic             rst,       // async reset, high
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // write word
  output logic                  out_valid, // output word present
  input  wire logic             out_ready, // consumer takes word
  output logic      [WIDTH-1:0] out_data   // output word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             push, pop;

  always_comb begin
    // the output register is one of the DEPTH words, so a full buffer holds DEPTH in all
    in_ready       = (count + (AW+1)'(out_valid)) < (AW+1)'(DEPTH);
    push           = in_valid && in_ready;
    pop            = (count != '0) && (!out_valid || out_ready);
    next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count     = count + (AW+1)'(push) - (AW+1)'(pop);
    next_out_valid = pop || (out_valid && !out_ready);
    next_out_data  = pop ? mem[rd_ptr] : out_data;
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end
endmodule // byte_fifo

/* File: verilog/serial_flash_spi_front_end.sv */
// serial-peripheral front end of a NOR flash: framing, pause, protect freeze
// assumes every pin is asynchronous to clock; busy, tx_byte and range bits are local
`timescale 1ns/1ns
`include "flash_spi_regs.svh"

// Function
// - sample serial_in on each rising shift_timing
// - change serial_out only after falling shift_timing
// - deselected: serial_out released to high impedance
// - standby only after internal cycle finishes
// - pause keeps selection, releases output, ignores inputs
// - write protect freezes the protected range
// - modes 0 and 3, rise in, fall out
// - page program takes 1 to 256 bytes
// - 64 sectors, 256 pages, 256 bytes
// - sector is the smallest erase unit
// - pause starts and ends with clock low
// - deselect during pause resets serial logic
// - write commands need whole-byte clock count
module serial_flash_spi_front_end (
  input  wire logic                      clock,              // 100 MHz system clock
  input  wire logic                      rst,                // async reset, high
  input  wire logic                      shift_timing,       // serial clock pin
  input  wire logic                      chip_select_n,      // chip select pin, low active
  input  wire logic                      pause_n,            // pause pin, low active
  input  wire logic                      write_protect_n,    // write protect pin, low active
  input  wire logic                      serial_in,          // serial data in pin
  output logic                           serial_out,         // serial data out pin value
  output logic                           serial_out_oe_n,    // low while driving serial_out
  input  wire logic                      protect_range_bit2, // protected range, status bit 2
  input  wire logic                      protect_range_bit1, // protected range, status bit 1
  input  wire logic                      protect_range_bit0, // protected range, status bit 0
  input  wire logic                      busy,               // internal write cycle running
  input  wire logic [7:0]                tx_byte,            // next byte to shift out
  output logic                           rx_valid,           // received byte present
  input  wire logic                      rx_ready,           // consumer takes byte
  output flash_spi_pkg::rx_byte_t        rx_byte,            // received byte, first marks command
  output logic                           frame_done,         // one-cycle pulse at frame end
  output flash_spi_pkg::frame_rpt_t      frame_rpt,          // report of the last frame
  output flash_spi_pkg::flash_addr_t     addr,               // address of the current frame
  output logic                           standby,            // deselected and idle
  output logic [2:0]                     protect_range,      // effective protected range
  output logic                           protect_frozen      // range held by write protect
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [4:0] sync1, sync2;
  logic       sck_prev, cs_prev;
  logic       sck_s, cs_s, pause_s, wp_s, si_s;
  logic       sck_rise, sck_fall, cs_fall, cs_rise;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1    <= '0;
      sync2    <= '0;
      sck_prev <= 1'b0;
      cs_prev  <= 1'b0;
    end else begin
      sync1    <= {shift_timing, chip_select_n, pause_n, write_protect_n, serial_in};
      sync2    <= sync1;
      sck_prev <= sync2[4];
      cs_prev  <= sync2[3];
    end
  end

  // edges come from the second stage only; either idle clock level works
  always_comb begin
    {sck_s, cs_s, pause_s, wp_s, si_s} = sync2;
    sck_rise = sck_s && !sck_prev;
    sck_fall = !sck_s && sck_prev;
    cs_fall  = !cs_s && cs_prev;
    cs_rise  = cs_s && !cs_prev;
  end

  // ****************************************************************
  // framing, shifting and pause control
  // ****************************************************************
  flash_spi_pkg::link_state_t  state, next_state;
  logic [2:0]                  bit_cnt, next_bit_cnt;
  logic [7:0]                  shreg, next_shreg, new_byte;
  logic [7:0]                  tx_shift, next_tx_shift;
  logic [9:0]                  byte_cnt, next_byte_cnt;
  logic [23:0]                 addr_sh, next_addr_sh;
  logic                        next_serial_out, next_oe_n, next_standby;
  logic                        push, next_push, overrun, next_overrun;
  flash_spi_pkg::rx_byte_t     push_data, next_push_data;
  logic                        next_frame_done;
  flash_spi_pkg::frame_rpt_t   next_frame_rpt;
  flash_spi_pkg::flash_addr_t  next_addr;
  logic                        fifo_in_ready;

  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_tx_shift   = tx_shift;
    next_byte_cnt   = byte_cnt;
    next_addr_sh    = addr_sh;
    next_serial_out = serial_out;
    next_push       = 1'b0;
    next_push_data  = push_data;
    next_overrun    = overrun || (push && !fifo_in_ready);
    next_frame_done = 1'b0;
    next_frame_rpt  = frame_rpt;
    next_addr       = addr;
    new_byte        = {shreg[6:0], si_s};
    unique case (state)
      flash_spi_pkg::ST_UNARMED, flash_spi_pkg::ST_DESEL: begin
        // a select while pause is low is not a frame; the master must raise it first
        if (cs_fall) begin
          next_state    = pause_s ? flash_spi_pkg::ST_ACTIVE : flash_spi_pkg::ST_DESEL;
          next_bit_cnt  = `BIT_FIRST;
          next_byte_cnt = '0;
          next_overrun  = push && !fifo_in_ready;
          next_tx_shift = tx_byte;
        end
      end
      flash_spi_pkg::ST_ACTIVE: begin
        if (cs_s) begin
          next_state             = flash_spi_pkg::ST_DESEL;
          next_frame_done        = 1'b1;
          next_frame_rpt.aligned = (bit_cnt == `BIT_FIRST);
          next_frame_rpt.page_fit = (bit_cnt == `BIT_FIRST) && (byte_cnt >= `PP_BYTES_MIN)
                                    && (byte_cnt <= `PP_BYTES_MAX);
          next_frame_rpt.overrun = next_overrun;
          next_frame_rpt.bytes   = byte_cnt;
        end else begin
          if (sck_rise) begin
            next_shreg   = new_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `BIT_LAST) begin
              next_push      = 1'b1;
              next_push_data = '{first: (byte_cnt == '0), data: new_byte};
              next_tx_shift  = tx_byte;
              if (byte_cnt != `BYTE_CNT_MAX) begin
                next_byte_cnt = byte_cnt + 10'h001;
              end
              if (byte_cnt >= `ADDR_BYTE_FIRST && byte_cnt <= `ADDR_BYTE_LAST) begin
                next_addr_sh = {addr_sh[15:0], new_byte};
              end
              if (byte_cnt == `ADDR_BYTE_LAST) begin
                // sector is the coarsest field; no erase unit below it exists
                next_addr.sector = next_addr_sh[`SECTOR_MSB:`SECTOR_LSB];
                next_addr.page   = next_addr_sh[`PAGE_MSB:`PAGE_LSB];
                next_addr.column = next_addr_sh[`COLUMN_MSB:`COLUMN_LSB];
              end
            end
          end
          if (sck_fall) begin
            next_serial_out = tx_shift[7];
            next_tx_shift   = {tx_shift[6:0], 1'b0};
          end
          if (!pause_s && !sck_s) begin
            next_state = flash_spi_pkg::ST_PAUSE;
          end
        end
      end
      flash_spi_pkg::ST_PAUSE: begin
        // clock and data are ignored here; a deselect drops the partial frame
        if (cs_s) begin
          next_state    = flash_spi_pkg::ST_DESEL;
          next_bit_cnt  = `BIT_FIRST;
          next_byte_cnt = '0;
        end else if (pause_s && !sck_s) begin
          next_state = flash_spi_pkg::ST_ACTIVE;
        end
      end
    endcase
    next_oe_n    = (next_state != flash_spi_pkg::ST_ACTIVE);
    next_standby = (next_state == flash_spi_pkg::ST_UNARMED || next_state == flash_spi_pkg::ST_DESEL)
                   && !busy;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state           <= flash_spi_pkg::ST_UNARMED;
      bit_cnt         <= `BIT_FIRST;
      shreg           <= '0;
      tx_shift        <= '0;
      byte_cnt        <= '0;
      addr_sh         <= '0;
      serial_out      <= 1'b0;
      serial_out_oe_n <= 1'b1;
      standby         <= 1'b0;
      push            <= 1'b0;
      push_data       <= '0;
      overrun         <= 1'b0;
      frame_done      <= 1'b0;
      frame_rpt       <= '0;
      addr            <= '0;
    end else begin
      state           <= next_state;
      bit_cnt         <= next_bit_cnt;
      shreg           <= next_shreg;
      tx_shift        <= next_tx_shift;
      byte_cnt        <= next_byte_cnt;
      addr_sh         <= next_addr_sh;
      serial_out      <= next_serial_out;
      serial_out_oe_n <= next_oe_n;
      standby         <= next_standby;
      push            <= next_push;
      push_data       <= next_push_data;
      overrun         <= next_overrun;
      frame_done      <= next_frame_done;
      frame_rpt       <= next_frame_rpt;
      addr            <= next_addr;
    end
  end

  // ****************************************************************
  // protected range freeze
  // ****************************************************************
  logic [2:0] next_protect_range;
  logic       next_protect_frozen;

  // range follows the status bits only while protect is released
  always_comb begin
    next_protect_frozen = !wp_s;
    next_protect_range  = wp_s ? {protect_range_bit2, protect_range_bit1, protect_range_bit0}
                               : protect_range;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      protect_range  <= '0;
      protect_frozen <= 1'b0;
    end else begin
      protect_range  <= next_protect_range;
      protect_frozen <= next_protect_frozen;
    end
  end

  // ****************************************************************
  // receive buffer
  // ****************************************************************
  // the serial side cannot stall, so a full buffer marks the frame overrun
  byte_fifo #(
    .WIDTH (`RX_FIFO_WIDTH),
    .DEPTH (`RX_FIFO_DEPTH)
  ) rx_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_byte)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_pause_entry;
    state == flash_spi_pkg::ST_ACTIVE ##1 state == flash_spi_pkg::ST_PAUSE;
  endsequence
  sequence s_frame_close;
    state == flash_spi_pkg::ST_ACTIVE && cs_s ##1 frame_done;
  endsequence

  property p_rise_sample;
    state == flash_spi_pkg::ST_ACTIVE && !cs_s && sck_rise |=> shreg[0] == $past(si_s);
  endproperty
  a_rise_sample: assert property (p_rise_sample) else $error("input bit not sampled");

  property p_out_on_fall;
    $changed(serial_out) |-> $past(sck_fall) && $past(state) == flash_spi_pkg::ST_ACTIVE;
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off a fall");

  property p_desel_release;
    cs_s [*2] |=> serial_out_oe_n;
  endproperty
  a_desel_release: assert property (p_desel_release) else $error("output driven while deselected");

  property p_standby_busy;
    busy |=> !standby;
  endproperty
  a_standby_busy: assert property (p_standby_busy) else $error("standby during internal cycle");

  property p_unarmed_wait;
    state == flash_spi_pkg::ST_UNARMED && !cs_fall |=> state == flash_spi_pkg::ST_UNARMED && !push;
  endproperty
  a_unarmed_wait: assert property (p_unarmed_wait) else $error("traffic before first select");

  property p_pause_hold;
    state == flash_spi_pkg::ST_PAUSE && !cs_s |=> $stable(shreg) && $stable(bit_cnt)
      && (serial_out_oe_n == (state != flash_spi_pkg::ST_ACTIVE));
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause did not freeze the link");

  property p_pause_clock_low;
    s_pause_entry |-> !$past(sck_s);
  endproperty
  a_pause_clock_low: assert property (p_pause_clock_low) else $error("pause began with clock high");

  property p_pause_desel;
    state == flash_spi_pkg::ST_PAUSE && cs_s |=> state == flash_spi_pkg::ST_DESEL ##1 !frame_done;
  endproperty
  a_pause_desel: assert property (p_pause_desel) else $error("deselect in pause kept frame");

  property p_frame_aligned;
    s_frame_close |-> frame_rpt.aligned == ($past(bit_cnt) == `BIT_FIRST);
  endproperty
  a_frame_aligned: assert property (p_frame_aligned) else $error("bit alignment misreported");

  property p_range_frozen;
    !wp_s |=> protect_range == $past(protect_range);
  endproperty
  a_range_frozen: assert property (p_range_frozen) else $error("range moved while protected");
endmodule // serial_flash_spi_front_end

/* File: tb/spi_master_model.sv */
// bus master model that drives the serial flash pins in mode 0 or mode 3
// assumes the caller lets each frame close; the link clock runs only inside frames
`timescale 1ns/1ns
module spi_master_model (
  output logic       shift_timing,  // serial clock
  output logic       chip_select_n, // select, low active
  output logic       pause_n,       // pause, low active
  output logic       serial_in,     // data to the device
  input  wire logic  serial_out,    // data from the device
  output logic [7:0] miso           // bits captured from the device
);
  logic mode;

  initial begin
    shift_timing = 1'b0;
    chip_select_n = 1'b0;
    pause_n = 1'b1;
    serial_in = 1'b0;
    miso = 8'h00;
    mode = 1'b0;
  end

  task automatic select(input logic m);
    #3 mode = m;
    shift_timing = m;
    #80 chip_select_n = 1'b0;
    #80;
  endtask

  // top n bits, msb first; sampled late in the high phase since sync delay eats the low phase
  task automatic send(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      shift_timing = 1'b0;
      serial_in = b[7-i];
      #40 shift_timing = 1'b1;
      #39 miso = {miso[6:0], serial_out};
      #1;
    end
  endtask

  task automatic deselect();
    #40 shift_timing = mode;
    #40 chip_select_n = 1'b1;
    serial_in = ~serial_in; // released line keeps no last value
    #120;
  endtask

  // pause edges only while the clock is low
  task automatic hold(input logic on);
    shift_timing = 1'b0;
    #40 pause_n = ~on;
    #80;
  endtask
endmodule // spi_master_model

/* File: tb/tb_top.sv */
// self-checking bench of the serial flash front end with a bus master model
// assumes the design and package compile first; link edges are unrelated to clock
`timescale 1ns/1ns
module tb_top;
  logic                        clock, rst, write_protect_n, busy, rx_ready, rx_valid;
  logic                        frame_done, standby, protect_frozen, serial_out, serial_out_oe_n;
  logic                        shift_timing, chip_select_n, pause_n, serial_in;
  logic                        miso_line;
  logic [2:0]                  range_bits, protect_range;
  logic [7:0]                  tx_byte, miso;
  flash_spi_pkg::rx_byte_t     rx_byte;
  flash_spi_pkg::frame_rpt_t   frame_rpt, rpt;
  flash_spi_pkg::flash_addr_t  addr;
  flash_spi_pkg::rx_byte_t     q[$];
  int                          fails = 0;
  int                          n_compared = 0;
  int                          n_done = 0;

  serial_flash_spi_front_end uut (.clock(clock), .rst(rst), .shift_timing(shift_timing),
    .chip_select_n(chip_select_n), .pause_n(pause_n), .write_protect_n(write_protect_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .protect_range_bit2(range_bits[2]), .protect_range_bit1(range_bits[1]),
    .protect_range_bit0(range_bits[0]), .busy(busy), .tx_byte(tx_byte), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .frame_done(frame_done), .frame_rpt(frame_rpt),
    .addr(addr), .standby(standby), .protect_range(protect_range), .protect_frozen(protect_frozen));

  spi_master_model master (.shift_timing(shift_timing), .chip_select_n(chip_select_n),
    .pause_n(pause_n), .serial_in(serial_in), .serial_out(miso_line), .miso(miso));

  // a released line has no pull, so the master sees the inverse rather than a stale bit
  assign miso_line = serial_out_oe_n ? ~serial_out : serial_out;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // a frame_done longer than one cycle counts twice and shows up as a mismatch
  // looked at just after the falling edge: outputs settled, inputs already changed
  always @(negedge clock) begin
    #1;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) q.push_back(rx_byte);
    if (frame_done === 1'b1) begin
      rpt = frame_rpt;
      n_done++;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic chk_rpt(input logic a, input logic f, input logic o, input logic [9:0] n);
    chk({19'h0, rpt}, {19'h0, a, f, o, n});
  endtask

  task automatic frame(input logic m, input logic [7:0] b[$]);
    int d;
    d = n_done;
    master.select(m);
    foreach (b[i]) master.send(b[i], 8);
    master.deselect();
    settle(20);
    chk(32'(n_done - d), 32'h1);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_unarmed();
    master.send(8'hC3, 8);
    master.send(8'h3C, 8);
    master.deselect();
    settle(20);
    chk(32'(n_done), 32'h0);
    chk(32'(q.size()), 32'h0);
    chk({31'h0, standby}, 32'h1);
  endtask

  task automatic t_write();
    logic [7:0] b[$];
    b = '{8'h02, 8'hFF, 8'hAB, 8'hCD, 8'h11, 8'h22};
    q.delete();
    frame(1'b0, b);
    chk(32'(q.size()), 32'h6);
    for (int i = 0; i < 6; i++) chk({23'h0, q[i]}, {23'h0, i == 0, b[i]});
    chk({10'h0, addr}, {10'h0, 6'h3F, 8'hAB, 8'hCD});
    chk_rpt(1'b1, 1'b1, 1'b0, 10'h006);
  endtask

  task automatic t_read();
    tx_byte = 8'hC6;
    q.delete();
    master.select(1'b1);
    for (int i = 0; i < 3; i++) begin
      settle(1);
      // taken at this byte's last rise, so it is the next byte's answer
      tx_byte = 8'hC6 ^ 8'(i + 1);
      master.send(8'h0B, 8);
      chk({24'h0, miso}, 32'(8'hC6 ^ 8'(i)));
      chk({31'h0, serial_out_oe_n}, 32'h0);
    end
    master.deselect();
    settle(20);
    chk({31'h0, serial_out_oe_n}, 32'h1);
    chk(32'(q.size()), 32'h3);
    chk_rpt(1'b1, 1'b0, 1'b0, 10'h003);
  endtask

  task automatic t_partial();
    master.select(1'b0);
    master.send(8'h06, 8);
    master.send(8'hE0, 3);
    master.deselect();
    settle(20);
    chk_rpt(1'b0, 1'b0, 1'b0, 10'h001);
  endtask

  // consumer stalls through the frame, then drains the full buffer
  task automatic t_fifo();
    rx_ready = 1'b0;
    q.delete();
    master.select(1'b0);
    for (int i = 0; i < 40; i++) master.send(8'(i), 8);
    master.deselect();
    settle(20);
    chk_rpt(1'b1, 1'b1, 1'b1, 10'h028);
    chk({31'h0, rx_valid}, 32'h1);
    rx_ready = 1'b1;
    settle(40);
    chk(32'(q.size()), 32'h20);
    chk({23'h0, q[0]}, 32'h100);
    chk({23'h0, q[31]}, 32'h1F);
    chk({31'h0, rx_valid}, 32'h0);
  endtask

  task automatic t_bound();
    int n[4] = '{4, 5, 260, 261};
    logic fit[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [7:0] b[$];
    for (int k = 0; k < 4; k++) begin
      b.delete();
      for (int i = 0; i < n[k]; i++) b.push_back(8'(i + 2));
      frame(1'b0, b);
      chk({31'h0, rpt.page_fit}, {31'h0, fit[k]});
      chk({22'h0, rpt.bytes}, 32'(n[k]));
    end
    q.delete();
  endtask

  task automatic t_pause();
    int d;
    q.delete();
    master.select(1'b0);
    master.send(8'h9A, 8);
    master.hold(1'b1);
    chk({31'h0, serial_out_oe_n}, 32'h1);
    master.send(8'hFF, 8);
    master.hold(1'b0);
    chk({31'h0, serial_out_oe_n}, 32'h0);
    master.send(8'h5B, 8);
    master.deselect();
    settle(20);
    chk({23'h0, q[1]}, 32'h5B);
    chk_rpt(1'b1, 1'b0, 1'b0, 10'h002);
    d = n_done;
    master.select(1'b0);
    master.send(8'h01, 8);
    master.hold(1'b1);
    master.deselect();
    master.hold(1'b0);
    settle(20);
    chk(32'(n_done - d), 32'h0);
    frame(1'b0, '{8'h04});
    chk_rpt(1'b1, 1'b0, 1'b0, 10'h001);
  endtask

  task automatic t_protect();
    for (int k = 0; k < 8; k++) begin
      range_bits = 3'(k);
      settle(6);
      chk({28'h0, protect_frozen, protect_range}, 32'(k));
      write_protect_n = 1'b0;
      settle(6);
      range_bits = ~3'(k);
      settle(6);
      chk({28'h0, protect_frozen, protect_range}, 32'(k + 8));
      write_protect_n = 1'b1;
      settle(6);
      chk({28'h0, protect_frozen, protect_range}, 32'(7 - k));
    end
  endtask

  task automatic t_standby();
    busy = 1'b1;
    master.select(1'b0);
    chk({31'h0, standby}, 32'h0);
    master.deselect();
    settle(4);
    chk({31'h0, standby}, 32'h0);
    busy = 1'b0;
    settle(3);
    chk({31'h0, standby}, 32'h1);
  endtask

  initial begin
    rst = 1'b1;
    write_protect_n = 1'b1;
    busy = 1'b0;
    rx_ready = 1'b1;
    tx_byte = 8'h00;
    range_bits = 3'h0;
    settle(20);
    chk({27'h0, serial_out_oe_n, rx_valid, frame_done, standby, protect_frozen}, 32'h10);
    rst = 1'b0;
    settle(3);
    t_unarmed();
    t_write();
    t_read();
    t_partial();
    t_fifo();
    t_bound();
    t_pause();
    t_protect();
    t_standby();
    close_out();
  end

  // run needs about 40k cycles; two and a half times that means a hang
  initial begin
    #1_000_000;
    fails++;
    close_out();
  end
endmodule // tb_top
